// file: common/scpsc_consts.svh
// scpsc constants: command codes, register offsets, field bits, reset values.
// assumes: included by the core file; packages hold only types.
`ifndef SCPSC_CONSTS_SVH
`define SCPSC_CONSTS_SVH
`define SCPSC_CMD_IFRST 8'h7A
`define SCPSC_CMD_SETPTR 8'h7D
`define SCPSC_CMD_WRITE 8'h7E
`define SCPSC_CMD_READ 8'h7F
`define SCPSC_OFS_CTRL 8'h00
`define SCPSC_OFS_STAT 8'h02
`define SCPSC_OFS_TOUCH 8'h03
`define SCPSC_OFS_SBYCH 8'h04
`define SCPSC_BIT_INT 0
`define SCPSC_BIT_DEEP_SLEEP_BIT 4
`define SCPSC_BIT_STANDBY_REQUEST_BIT 5
`define SCPSC_BIT_RSTST 0
`define SCPSC_CTRL_RST 8'h00
`define SCPSC_SBYCH_RST 8'h01
`define SCPSC_ACTCH_RST 8'hFF
`define SCPSC_PIN_RST 5'h08
`endif

// file: common/scpsc_pkg.sv
// scpsc types: power states, serial phases, byte event kinds.
// assumes: compiled before the core file.
package scpsc_pkg;
	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_STANDBY = 2'b01,
		PWR_DEEP = 2'b10
	} scpsc_pwr_t;
	typedef enum logic [1:0] {
		PH_CMD = 2'b00,
		PH_PTR = 2'b01,
		PH_WDATA = 2'b10,
		PH_RDATA = 2'b11
	} scpsc_phase_t;
	typedef enum logic [1:0] {
		EV_NONE = 2'b00,
		EV_PTR = 2'b01,
		EV_WR = 2'b10,
		EV_RD = 2'b11
	} scpsc_evt_t;
endpackage

// file: rtl/scpsc_core.sv
// scpsc core: serial command engine (link clock) and power-state manager (clk).
// assumes: spi mode 0, spi_clk stopped while spi_cs_n high; pins asynchronous to clk.
`include "scpsc_consts.svh"
module scpsc_core (
	input wire logic clk, // core clock, 200 MHz
	input wire logic srst, // synchronous reset, active high
	input wire logic spi_clk, // serial clock from host
	input wire logic spi_cs_n, // serial chip select, active low
	input wire logic bidir_serial_data_pin_i, // shared wake / data pin, input side
	output logic bidir_serial_data_pin_o, // shared pin, output value
	output logic bidir_serial_data_pin_oe_n, // shared pin, low while driven
	output logic spi_miso, // four-wire serial data out
	input wire logic four_wire_sel, // strap: high selects four-wire mode
	input wire logic reset_pin, // device reset, active high
	input wire logic [7:0] touch_in, // per-channel touch detect from sensing
	output scpsc_pkg::scpsc_pwr_t pwr_state, // current power state
	output logic [7:0] sense_ch_en, // channels allowed to sample
	output logic pwm_en, // led pwm allowed
	output logic led_static, // leds held at non-actuated level
	output logic led_drive_en, // leds may be driven at all
	output logic int_bit, // interrupt bit of control register
	output logic reset_status, // reset status bit
	output logic [7:0] touch_status // touch status register
);
	// core-side pin synchroniser: {four_wire, cs_n, pin, reset, event toggle}
	logic [4:0] ps1_r;
	logic [4:0] ps2_r;
	logic [4:0] ps3_r;
	logic [4:0] lvl_r;
	logic [4:0] lvl_nxt;
	logic evt_tgl_r;
	logic m4_lvl;
	logic cs_lvl;
	logic pin_lvl;
	logic rst_lvl;
	logic core_rst;

	assign lvl_nxt = ((ps2_r ~^ ps3_r) & ps3_r) | ((ps2_r ^ ps3_r) & lvl_r);
	assign m4_lvl = lvl_r[4];
	assign cs_lvl = lvl_r[3];
	assign pin_lvl = lvl_r[2];
	assign rst_lvl = lvl_r[1];
	assign core_rst = srst | rst_lvl;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ps1_r <= `SCPSC_PIN_RST;
			ps2_r <= `SCPSC_PIN_RST;
			ps3_r <= `SCPSC_PIN_RST;
			lvl_r <= `SCPSC_PIN_RST;
		end
		else
		begin
			ps1_r <= {four_wire_sel, spi_cs_n, bidir_serial_data_pin_i, reset_pin, evt_tgl_r};
			ps2_r <= ps1_r;
			ps3_r <= ps2_r;
			lvl_r <= lvl_nxt;
		end
	end

	// link side: reset and mode are levels, two flip-flops each
	logic lrst_m_r;
	logic lrst_s_r;
	logic lm4_m_r;
	logic lm4_s_r;

	always_ff @(posedge spi_clk)
	begin
		lrst_m_r <= core_rst;
		lrst_s_r <= lrst_m_r;
		lm4_m_r <= m4_lvl;
		lm4_s_r <= lm4_m_r;
	end

	logic [2:0] bit_cnt_r;
	logic [6:0] sh_r;
	scpsc_pkg::scpsc_phase_t phase_r;
	scpsc_pkg::scpsc_phase_t phase_nxt;
	logic prev_ifr_r;
	scpsc_pkg::scpsc_evt_t evt_kind_r;
	logic [7:0] evt_byte_r;
	logic [7:0] rx_byte;
	logic byte_done;
	logic ifr_hit;
	logic evt_fire;
	logic [7:0] rd_buf_r;
	logic [7:0] tx_r;

	function automatic scpsc_pkg::scpsc_phase_t next_phase(scpsc_pkg::scpsc_phase_t ph, logic [7:0] b);
		scpsc_pkg::scpsc_phase_t r;
		r = scpsc_pkg::PH_CMD;
		if (ph == scpsc_pkg::PH_CMD)
		begin
			case (b)
				`SCPSC_CMD_SETPTR: r = scpsc_pkg::PH_PTR;
				`SCPSC_CMD_WRITE: r = scpsc_pkg::PH_WDATA;
				`SCPSC_CMD_READ: r = scpsc_pkg::PH_RDATA;
				default: r = scpsc_pkg::PH_CMD;
			endcase
		end
		return r;
	endfunction

	assign rx_byte = {sh_r, bidir_serial_data_pin_i};
	assign byte_done = (bit_cnt_r == 3'h7);
	assign ifr_hit = byte_done && prev_ifr_r && (rx_byte == `SCPSC_CMD_IFRST);
	assign phase_nxt = ifr_hit ? scpsc_pkg::PH_CMD : next_phase(phase_r, rx_byte);
	assign evt_fire = byte_done && !ifr_hit && (phase_r != scpsc_pkg::PH_CMD);

	// frame state; cs_n high ends any transaction, only constants on async reset
	always_ff @(posedge spi_clk or posedge spi_cs_n)
	begin
		if (spi_cs_n)
		begin
			bit_cnt_r <= 3'h0;
			sh_r <= 7'h00;
			phase_r <= scpsc_pkg::PH_CMD;
			prev_ifr_r <= 1'b0;
		end
		else if (lrst_s_r || ifr_hit)
		begin
			bit_cnt_r <= 3'h0;
			sh_r <= 7'h00;
			phase_r <= scpsc_pkg::PH_CMD;
			prev_ifr_r <= 1'b0;
		end
		else
		begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			sh_r <= rx_byte[6:0];
			if (byte_done)
			begin
				phase_r <= phase_nxt;
				prev_ifr_r <= (rx_byte == `SCPSC_CMD_IFRST);
			end
		end
	end

	// byte event to core; kind and byte stay put until the next byte ends
	always_ff @(posedge spi_clk)
	begin
		if (lrst_s_r)
		begin
			evt_tgl_r <= 1'b0;
			evt_kind_r <= scpsc_pkg::EV_NONE;
			evt_byte_r <= 8'h00;
		end
		else if (evt_fire)
		begin
			evt_tgl_r <= ~evt_tgl_r;
			evt_kind_r <= scpsc_pkg::scpsc_evt_t'(phase_r);
			evt_byte_r <= rx_byte;
		end
	end

	// shift out on falling edges; rd_buf_r settles early in the preceding byte, before it is taken
	always_ff @(negedge spi_clk or posedge spi_cs_n)
	begin
		if (spi_cs_n)
			tx_r <= 8'h00;
		else if (bit_cnt_r == 3'h0)
			tx_r <= rd_buf_r;
		else
			tx_r <= {tx_r[6:0], 1'b0};
	end

	logic wake_drv_r;
	logic rd_drive;
	assign rd_drive = !lm4_s_r && !spi_cs_n && (phase_r == scpsc_pkg::PH_RDATA);
	assign spi_miso = tx_r[7];
	assign bidir_serial_data_pin_o = wake_drv_r | tx_r[7];
	// wake drive uses the core-side mode level: the link copy stalls while spi_clk is idle
	assign bidir_serial_data_pin_oe_n = !(rd_drive || (wake_drv_r && !m4_lvl));

	// core: register file, pointer, power state
	logic evt_acc_r;
	logic evt_pulse;
	logic [7:0] ptr_r;
	logic [7:0] ctrl_r;
	logic rstst_r;
	logic [7:0] touch_r;
	logic [7:0] sbych_r;
	scpsc_pkg::scpsc_pwr_t pwr_r;
	scpsc_pkg::scpsc_pwr_t pwr_nxt;
	logic [7:0] sense_r;
	logic rst_prev_r;
	logic rst_fall;
	logic wr_ev;
	logic wake_hit;
	logic [7:0] new_touch;
	logic int_set;
	logic [7:0] ctrl_w;
	logic [7:0] ctrl_nxt;
	logic [7:0] touch_nxt;
	logic [7:0] rd_mux;
	logic [7:0] sbych_nxt;

	function automatic logic [7:0] mask_of(scpsc_pkg::scpsc_pwr_t p, logic [7:0] sby);
		logic [7:0] m;
		m = 8'h00;
		case (p)
			scpsc_pkg::PWR_ACTIVE: m = `SCPSC_ACTCH_RST;
			scpsc_pkg::PWR_STANDBY: m = sby;
			default: m = 8'h00;
		endcase
		return m;
	endfunction

	function automatic logic wr_at(logic ev, logic [7:0] p, logic [7:0] ofs);
		return ev && (p == ofs);
	endfunction

	assign evt_pulse = lvl_r[0] ^ evt_acc_r;
	assign wr_ev = evt_pulse && (evt_kind_r == scpsc_pkg::EV_WR);
	assign rst_fall = rst_prev_r && !rst_lvl;
	assign wake_hit = !m4_lvl && pin_lvl && (pwr_r == scpsc_pkg::PWR_DEEP) && !core_rst;
	assign new_touch = touch_in & sense_r & ~touch_r;
	assign int_set = (|new_touch) || rst_fall;
	assign ctrl_w = wr_at(wr_ev, ptr_r, `SCPSC_OFS_CTRL) ? evt_byte_r : ctrl_r;
	// hardware set of int wins over a software clear in the same cycle
	assign ctrl_nxt = (ctrl_w & ~({7'h00, wake_hit} << `SCPSC_BIT_DEEP_SLEEP_BIT))
		| ({7'h00, int_set} << `SCPSC_BIT_INT);
	// masks follow the new standby set in the cycle it is written
	assign sbych_nxt = wr_at(wr_ev, ptr_r, `SCPSC_OFS_SBYCH) ? evt_byte_r : sbych_r;
	assign touch_nxt = ((wr_at(wr_ev, ptr_r, `SCPSC_OFS_TOUCH) ? evt_byte_r : touch_r) | new_touch)
		& mask_of(pwr_nxt, sbych_nxt);
	// deep sleep outranks standby; traffic only lifts it while cs is low
	assign pwr_nxt = core_rst ? scpsc_pkg::PWR_DEEP
		: ctrl_r[`SCPSC_BIT_DEEP_SLEEP_BIT] ? (cs_lvl ? scpsc_pkg::PWR_DEEP : scpsc_pkg::PWR_ACTIVE)
		: ctrl_r[`SCPSC_BIT_STANDBY_REQUEST_BIT] ? scpsc_pkg::PWR_STANDBY : scpsc_pkg::PWR_ACTIVE;
	assign rd_mux = (ptr_r == `SCPSC_OFS_CTRL) ? ctrl_r
		: (ptr_r == `SCPSC_OFS_STAT) ? {7'h00, rstst_r}
		: (ptr_r == `SCPSC_OFS_TOUCH) ? touch_r
		: (ptr_r == `SCPSC_OFS_SBYCH) ? sbych_r : 8'h00;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			evt_acc_r <= 1'b0;
			rst_prev_r <= 1'b0;
		end
		else
		begin
			evt_acc_r <= lvl_r[0];
			rst_prev_r <= rst_lvl;
		end
	end

	always_ff @(posedge clk)
	begin
		if (core_rst)
			ptr_r <= 8'h00;
		else if (evt_pulse && (evt_kind_r == scpsc_pkg::EV_PTR))
			ptr_r <= evt_byte_r;
		else if (evt_pulse && (evt_kind_r != scpsc_pkg::EV_NONE))
			ptr_r <= ptr_r + 8'h01;
	end

	always_ff @(posedge clk)
	begin
		if (core_rst)
		begin
			ctrl_r <= `SCPSC_CTRL_RST;
			touch_r <= 8'h00;
			sbych_r <= `SCPSC_SBYCH_RST;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			touch_r <= touch_nxt;
			sbych_r <= sbych_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (core_rst)
			rstst_r <= 1'b0;
		else if (rst_fall)
			rstst_r <= 1'b1;
		else if (wr_at(wr_ev, ptr_r, `SCPSC_OFS_STAT))
			rstst_r <= evt_byte_r[`SCPSC_BIT_RSTST];
	end

	always_ff @(posedge clk)
	begin
		if (core_rst)
		begin
			pwr_r <= scpsc_pkg::PWR_DEEP;
			sense_r <= 8'h00;
			wake_drv_r <= 1'b0;
			rd_buf_r <= 8'h00;
		end
		else
		begin
			pwr_r <= pwr_nxt;
			sense_r <= mask_of(pwr_nxt, sbych_nxt);
			wake_drv_r <= (!m4_lvl && (pwr_r == scpsc_pkg::PWR_STANDBY) && (|new_touch))
				|| (wake_drv_r && ctrl_r[`SCPSC_BIT_INT]);
			rd_buf_r <= rd_mux;
		end
	end

	assign pwr_state = pwr_r;
	assign sense_ch_en = sense_r;
	assign pwm_en = (pwr_r != scpsc_pkg::PWR_DEEP);
	assign led_static = (pwr_r == scpsc_pkg::PWR_DEEP);
	assign led_drive_en = !rst_lvl;
	assign int_bit = ctrl_r[`SCPSC_BIT_INT];
	assign reset_status = rstst_r;
	assign touch_status = touch_r;

	AST_IFRST: assert property (
		@(posedge spi_clk) disable iff (spi_cs_n || lrst_s_r)
		ifr_hit |=> (phase_r == scpsc_pkg::PH_CMD) && (bit_cnt_r == 3'h0))
		else $error("interface reset did not return to command phase");
	AST_PTR_LOAD: assert property (
		@(posedge clk) disable iff (core_rst)
		(evt_pulse && evt_kind_r == scpsc_pkg::EV_PTR) |=> (ptr_r == $past(evt_byte_r)))
		else $error("pointer not loaded by set-pointer");
	AST_WR_INC: assert property (
		@(posedge clk) disable iff (core_rst)
		wr_ev |=> (ptr_r == $past(ptr_r) + 8'h01))
		else $error("pointer not incremented after write");
	AST_RD_INC: assert property (
		@(posedge clk) disable iff (core_rst)
		(evt_pulse && evt_kind_r == scpsc_pkg::EV_RD) |=> (ptr_r == $past(ptr_r) + 8'h01))
		else $error("pointer not incremented after read");
	AST_DEEP_QUIET: assert property (
		@(posedge clk) disable iff (srst)
		(pwr_r == scpsc_pkg::PWR_DEEP) |-> (sense_ch_en == 8'h00) && !pwm_en && led_static)
		else $error("activity in deep sleep");
	AST_STANDBY_REQUEST_BIT_MASK: assert property (
		@(posedge clk) disable iff (core_rst)
		(pwr_r == scpsc_pkg::PWR_STANDBY) |-> (sense_ch_en == sbych_r))
		else $error("standby samples other channels");
	AST_RST_HOLD: assert property (
		@(posedge clk) disable iff (srst)
		rst_lvl |-> !led_drive_en ##1 ((pwr_r == scpsc_pkg::PWR_DEEP) && (ctrl_r == `SCPSC_CTRL_RST)))
		else $error("reset pin not holding deep sleep");
	AST_RST_STAT: assert property (
		@(posedge clk) disable iff (srst)
		rst_fall |=> reset_status && int_bit)
		else $error("reset release did not set status and int");
	AST_WAKE_CLR: assert property (
		@(posedge clk) disable iff (core_rst)
		wake_hit |=> !ctrl_r[`SCPSC_BIT_DEEP_SLEEP_BIT] ##1 (pwr_r != scpsc_pkg::PWR_DEEP))
		else $error("wake pin did not leave deep sleep");
	AST_WAKE_HOLD: assert property (
		@(posedge clk) disable iff (core_rst)
		(wake_drv_r && int_bit) |=> wake_drv_r)
		else $error("wake output dropped while int set");
	AST_TOUCH_DROP: assert property (
		@(posedge clk) disable iff (core_rst)
		1'b1 |-> ((touch_r & ~sense_r) == 8'h00))
		else $error("touch kept on inactive channel");
endmodule

// file: test/scpsc_host.sv
// host model: spi master for scpsc_core, mode 0, msb first.
// assumes: the bench resolves the shared pin and feeds miso_in.
module scpsc_host (
	output logic spi_clk, // serial clock, low outside frames except while idle runs
	output logic spi_cs_n, // chip select
	output logic mosi, // host data
	output logic mosi_oe, // host drives the data line
	input wire logic miso_in // data seen from the device
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		mosi = 1'b0;
		mosi_oe = 1'b0;
	end
	task automatic start;
		#1.3 spi_cs_n = 1'b0;
		mosi_oe = 1'b1;
		#20;
	endtask
	// rel frees the line for a bidir read byte
	task automatic xfer(input logic [7:0] tx, input logic rel, output logic [7:0] rx);
		mosi_oe = !rel;
		for (int i = 7; i >= 0; i--)
		begin
			mosi = tx[i];
			#7.5 spi_clk = 1'b1;
			rx[i] = miso_in;
			#7.5 spi_clk = 1'b0;
		end
	endtask
	task automatic stop;
		#10 spi_cs_n = 1'b1;
		mosi_oe = 1'b0;
		#60;
	endtask
	// clocks with cs high, so link-side flops clear during reset
	task automatic idle(input int n);
		repeat (n)
		begin
			#7.5 spi_clk = 1'b1;
			#7.5 spi_clk = 1'b0;
		end
	endtask
	task automatic wake(input logic v);
		mosi = v;
		mosi_oe = v;
	endtask
endmodule

// file: test/tb_scpsc_core.sv
// testbench for scpsc_core: host model on the link, core pins driven here.
// assumes: scpsc_pkg compiled first, consts header on the include path.
`include "scpsc_consts.svh"
module tb_scpsc_core;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic srst, four_wire_sel, reset_pin;
	logic [7:0] touch_in, rx, sense_ch_en, touch_status;
	logic spi_clk, spi_cs_n, mosi, mosi_oe, pin, pin_o, pin_oe_n, spi_miso, miso;
	logic pwm_en, led_static, led_drive_en, int_bit, reset_status;
	scpsc_pkg::scpsc_pwr_t pwr_state;
	scpsc_pkg::scpsc_pwr_t pw_tab [5] = '{scpsc_pkg::PWR_ACTIVE, scpsc_pkg::PWR_STANDBY,
		scpsc_pkg::PWR_DEEP, scpsc_pkg::PWR_DEEP, scpsc_pkg::PWR_ACTIVE};
	logic [7:0] ctl_tab [5] = '{8'h00, 8'h20, 8'h10, 8'h30, 8'h00};
	logic [7:0] sen_tab [5] = '{8'hFF, 8'h5A, 8'h00, 8'h00, 8'hFF};
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	// pull-down holds the pin low when nobody drives it
	assign pin = !pin_oe_n ? pin_o : (mosi_oe ? mosi : 1'b0);
	assign miso = four_wire_sel ? spi_miso : pin;
	initial
	begin
		forever #2.5 clk = !clk;
	end
	scpsc_host u_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .mosi(mosi), .mosi_oe(mosi_oe),
		.miso_in(miso));
	scpsc_core u_dut (.clk(clk), .srst(srst), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
		.bidir_serial_data_pin_i(pin), .bidir_serial_data_pin_o(pin_o),
		.bidir_serial_data_pin_oe_n(pin_oe_n), .spi_miso(spi_miso), .four_wire_sel(four_wire_sel),
		.reset_pin(reset_pin), .touch_in(touch_in), .pwr_state(pwr_state), .sense_ch_en(sense_ch_en),
		.pwm_en(pwm_en), .led_static(led_static), .led_drive_en(led_drive_en), .int_bit(int_bit),
		.reset_status(reset_status), .touch_status(touch_status));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk_pwr(input scpsc_pkg::scpsc_pwr_t e);
		chk("pwr_state", {6'h00, e}, {6'h00, pwr_state});
	endtask
	task automatic xb(input logic [7:0] b, input logic rel = 1'b0);
		u_host.xfer(b, rel, rx);
	endtask
	// reply bytes of set-pointer and write are stale, so they are dropped
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.start();
		xb(`SCPSC_CMD_SETPTR);
		xb(a);
		xb(`SCPSC_CMD_WRITE);
		xb(d);
		u_host.stop();
		w(12);
	endtask
	task automatic rd(input logic [7:0] a);
		u_host.start();
		xb(`SCPSC_CMD_SETPTR);
		xb(a);
		xb(`SCPSC_CMD_READ);
		xb(8'h00, 1'b1);
		u_host.stop();
		w(12);
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			end_of_test();
		end
	end
	initial
	begin
		srst = 1'b1;
		four_wire_sel = 1'b1;
		reset_pin = 1'b0;
		touch_in = 8'h00;
		u_host.idle(3);
		w(4);
		chk_pwr(scpsc_pkg::PWR_DEEP);
		@(posedge clk) srst <= 1'b0;
		w(12);
		u_host.idle(3); // link reset copy clears only on serial clocks
		chk_pwr(scpsc_pkg::PWR_ACTIVE);
		chk("sense", 8'hFF, sense_ch_en);
		chk("pwm_led", 8'h02, {6'h00, pwm_en, led_static});
		chk("oe_n", 8'h01, {7'h00, pin_oe_n});
		rd(`SCPSC_OFS_SBYCH);
		chk("sbych", `SCPSC_SBYCH_RST, rx);
		$display("test reset done");
		// second write lands on the unmapped 05h and is lost
		u_host.start();
		xb(`SCPSC_CMD_SETPTR);
		xb(`SCPSC_OFS_SBYCH);
		xb(`SCPSC_CMD_WRITE);
		xb(8'h5A);
		xb(`SCPSC_CMD_WRITE);
		xb(8'h77);
		u_host.stop();
		w(12);
		u_host.start();
		xb(`SCPSC_CMD_SETPTR);
		xb(`SCPSC_OFS_TOUCH);
		xb(`SCPSC_CMD_READ);
		xb(8'h00);
		chk("rd03", 8'h00, rx);
		xb(`SCPSC_CMD_READ);
		xb(8'h00);
		chk("rd04", 8'h5A, rx);
		xb(`SCPSC_CMD_READ);
		xb(8'h00);
		chk("rd05", 8'h00, rx);
		u_host.stop();
		w(12);
		$display("test pointer done");
		u_host.start();
		xb(`SCPSC_CMD_SETPTR);
		xb(`SCPSC_OFS_SBYCH);
		u_host.stop();
		u_host.start();
		// in the address phase the first 7Ah is still taken as the address
		xb(`SCPSC_CMD_SETPTR);
		xb(`SCPSC_CMD_IFRST);
		xb(`SCPSC_CMD_IFRST);
		xb(`SCPSC_CMD_READ);
		xb(8'h00);
		chk("ifrst_data", 8'h00, rx);
		xb(`SCPSC_CMD_SETPTR);
		xb(`SCPSC_OFS_SBYCH);
		xb(`SCPSC_CMD_IFRST);
		xb(`SCPSC_CMD_IFRST);
		xb(`SCPSC_CMD_READ);
		xb(8'h00);
		chk("ifrst_ptr", 8'h5A, rx);
		u_host.stop();
		w(12);
		chk_pwr(scpsc_pkg::PWR_ACTIVE);
		$display("test ifrst done");
		for (int i = 0; i < 5; i++)
		begin
			wr(`SCPSC_OFS_CTRL, ctl_tab[i]);
			chk_pwr(pw_tab[i]);
			chk("sense", sen_tab[i], sense_ch_en);
			chk("pwm", {7'h00, pw_tab[i] != scpsc_pkg::PWR_DEEP}, {7'h00, pwm_en});
			chk("led_static", {7'h00, pw_tab[i] == scpsc_pkg::PWR_DEEP}, {7'h00, led_static});
		end
		$display("test states done");
		wr(`SCPSC_OFS_CTRL, 8'h10);
		u_host.start();
		w(10);
		chk_pwr(scpsc_pkg::PWR_ACTIVE);
		xb(`SCPSC_CMD_SETPTR);
		xb(`SCPSC_OFS_CTRL);
		xb(`SCPSC_CMD_READ);
		xb(8'h00);
		chk("ctrl", 8'h10, rx);
		u_host.stop();
		w(12);
		chk_pwr(scpsc_pkg::PWR_DEEP);
		$display("test bus wake done");
		u_host.wake(1'b1);
		w(12);
		chk_pwr(scpsc_pkg::PWR_DEEP);
		u_host.wake(1'b0);
		@(posedge clk) four_wire_sel <= 1'b0;
		w(12);
		u_host.wake(1'b1);
		w(12);
		chk_pwr(scpsc_pkg::PWR_ACTIVE);
		u_host.wake(1'b0);
		rd(`SCPSC_OFS_CTRL);
		chk("ctrl_bidir", 8'h00, rx);
		$display("test pin wake done");
		@(posedge clk) four_wire_sel <= 1'b1;
		touch_in <= 8'h81;
		w(12);
		chk("touch_act", 8'h81, touch_status);
		@(posedge clk) touch_in <= 8'h00;
		wr(`SCPSC_OFS_CTRL, 8'h20);
		chk("touch_drop", 8'h00, touch_status);
		chk("int_clr", 8'h00, {7'h00, int_bit});
		@(posedge clk) four_wire_sel <= 1'b0;
		w(12);
		@(posedge clk) touch_in <= 8'h03;
		@(posedge clk) touch_in <= 8'h00;
		w(8);
		chk("touch_sby", 8'h02, touch_status);
		chk("wake_pin", 8'h01, {6'h00, pin_oe_n, pin_o});
		// wake drive owns the pin, so int is cleared over four-wire
		@(posedge clk) four_wire_sel <= 1'b1;
		w(12);
		wr(`SCPSC_OFS_CTRL, 8'h10);
		chk("touch_deep", 8'h00, touch_status);
		@(posedge clk) four_wire_sel <= 1'b0;
		w(12);
		chk("wake_rel", 8'h02, {6'h00, pin_oe_n, pin_o});
		$display("test touch done");
		@(posedge clk) reset_pin <= 1'b1;
		u_host.idle(5);
		w(8);
		chk_pwr(scpsc_pkg::PWR_DEEP);
		chk("led_drive", 8'h00, {7'h00, led_drive_en});
		@(posedge clk) reset_pin <= 1'b0;
		w(12);
		u_host.idle(3);
		chk("rst_int", 8'h03, {6'h00, reset_status, int_bit});
		rd(`SCPSC_OFS_SBYCH);
		chk("sbych", `SCPSC_SBYCH_RST, rx);
		$display("test reset pin done");
		end_of_test();
	end
endmodule
